/* hw/mpb_pkg.sv */
// Constants, field layout and carrier types of the microphone gain and bias control.
// Assumes a 32-bit APB master and one 100 MHz clock. Register words are indexed, byte = 4 * index.
package mpb_pkg;

  // ----------------------------------------------------------------
  // Register map: paddr[9] is the page, paddr[8:2] the register index
  // ----------------------------------------------------------------
  localparam int unsigned    ADDR_W       = 10;
  localparam int unsigned    PAGE_BIT     = 9;
  localparam logic [6:0]     IDX_STATUS   = 7'h24;
  localparam logic [6:0]     IDX_PWR      = 7'h51;
  localparam logic [6:0]     IDX_MUTE     = 7'h52;
  localparam logic [6:0]     IDX_AGC      = 7'h56;
  localparam logic [6:0]     IDX_IRQ_STAT = 7'h7e;
  localparam logic [6:0]     IDX_IRQ_MASK = 7'h7f;
  localparam logic [6:0]     IDX_BIAS     = 7'h2e;
  localparam logic [6:0]     IDX_GAIN     = 7'h2f;
  localparam logic [6:0]     IDX_FF       = 7'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned    BIT_TOP      = 7;
  localparam int unsigned    BIT_POWERED  = 6;
  localparam int unsigned    FF_MIC_LSB   = 6;
  localparam int unsigned    FF_AUXILIARY_INPUT_ONE_LSB  = 4;
  localparam int unsigned    FF_AUXILIARY_INPUT_TWO_LSB  = 2;
  localparam int unsigned    IRQ_W        = 2;
  localparam int unsigned    IRQ_REACHED  = 0;
  localparam int unsigned    IRQ_PWR      = 1;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [6:0]     GAIN_ZERO    = 7'h00;
  localparam logic [6:0]     GAIN_MAX     = 7'h77;
  localparam logic [6:0]     GAIN_STEP    = 7'h01;
  localparam logic [8:0]     FF_SHIFT     = 9'h00c;
  localparam logic [1:0]     FF_NOMINAL   = 2'h0;
  localparam logic [1:0]     FF_PLUS      = 2'h1;
  localparam logic [1:0]     SS_NORMAL    = 2'h0;
  localparam logic [1:0]     SS_HALF      = 2'h1;
  localparam logic [31:0]    RD_ZERO      = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] bias;
    logic       amp_en;
    logic [6:0] gain;
    logic [1:0] ff_mic;
    logic [1:0] ff_auxiliary_input_one;
    logic [1:0] ff_auxiliary_input_two;
    logic       pwr;
    logic [1:0] ss;
    logic       mute;
    logic       agc_en;
  } mpb_ctrl_t;

  // Amplifier off, mute off, soft-stepping on, converter down
  localparam mpb_ctrl_t CTRL_RST = '0;

  // Effective gains in half-decibel units, two's complement
  typedef struct packed {
    logic [8:0] mic;
    logic [8:0] auxiliary_input_one;
    logic [8:0] auxiliary_input_two;
  } mpb_eff_gain_t;

endpackage : mpb_pkg

/* hw/mpb_ctrl.sv */
// Microphone bias, amplifier gain soft-stepping, feed-forward scaling, mute and power sequencing.
// Assumes APB master on pclk, an unrelated free-running internal oscillator on osc_clk_in,
// and AGC gain and converter samples produced on pclk.
`timescale 1ns/100ps
module mpb_ctrl #(
  parameter int unsigned DATA_W    = 16,
  parameter int unsigned STEP_DIV  = 8
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [mpb_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Internal oscillator, asynchronous to pclk
  input  wire logic                  osc_clk_in,
  // AGC loop and converter samples
  input  wire logic [6:0]            agc_gain_in,
  input  wire logic [DATA_W-1:0]     conv_data_in,
  input  wire logic                  conv_valid_in,
  // Analog control and data out
  output logic [1:0]                 mic_bias_output_q,
  output logic [6:0]                 applied_gain_q,
  output mpb_pkg::mpb_eff_gain_t     eff_gain_q,
  output logic                       conv_power_q,
  output logic [DATA_W-1:0]          conv_data_q,
  output logic                       conv_valid_q,
  output logic                       irq_q
);

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  mpb_pkg::mpb_ctrl_t            ctrl_q;
  logic [mpb_pkg::IRQ_W-1:0]     irq_stat_q;
  logic [mpb_pkg::IRQ_W-1:0]     irq_mask_q;
  logic                          reached;
  logic                          acc;
  logic                          wr_en;
  logic                          page1;
  logic [6:0]                    idx;
  logic [31:0]                   rd_d;
  logic                          hit_d;

  assign acc   = psel & penable & pready;
  assign wr_en = acc & pwrite;
  assign page1 = paddr[mpb_pkg::PAGE_BIT];
  assign idx   = paddr[mpb_pkg::PAGE_BIT-1:2];

  always_comb begin
    rd_d  = mpb_pkg::RD_ZERO;
    hit_d = 1'b1;
    if (page1) begin
      case (idx)
        mpb_pkg::IDX_BIAS: rd_d[1:0] = ctrl_q.bias;
        mpb_pkg::IDX_GAIN: rd_d[7:0] = {ctrl_q.amp_en, ctrl_q.gain};
        mpb_pkg::IDX_FF:   rd_d[7:2] = {ctrl_q.ff_mic, ctrl_q.ff_auxiliary_input_one, ctrl_q.ff_auxiliary_input_two};
        default:           hit_d     = 1'b0;
      endcase
    end else begin
      case (idx)
        mpb_pkg::IDX_STATUS: begin
          rd_d[mpb_pkg::BIT_TOP]     = reached;
          rd_d[mpb_pkg::BIT_POWERED] = conv_power_q;
        end
        mpb_pkg::IDX_PWR: begin
          rd_d[mpb_pkg::BIT_TOP] = ctrl_q.pwr;
          rd_d[1:0]              = ctrl_q.ss;
        end
        mpb_pkg::IDX_MUTE:     rd_d[mpb_pkg::BIT_TOP]     = ctrl_q.mute;
        mpb_pkg::IDX_AGC:      rd_d[mpb_pkg::BIT_TOP]     = ctrl_q.agc_en;
        mpb_pkg::IDX_IRQ_STAT: rd_d[mpb_pkg::IRQ_W-1:0]   = irq_stat_q;
        mpb_pkg::IDX_IRQ_MASK: rd_d[mpb_pkg::IRQ_W-1:0]   = irq_mask_q;
        default:               hit_d                      = 1'b0;
      endcase
    end
  end

  // One wait state: pready rises on the second access-phase cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= mpb_pkg::RD_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_d : mpb_pkg::RD_ZERO;
      pslverr <= psel & penable & ~pready & ~hit_d;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= mpb_pkg::CTRL_RST;
    end else if (wr_en && page1) begin
      case (idx)
        mpb_pkg::IDX_BIAS: ctrl_q.bias <= pwdata[1:0];
        mpb_pkg::IDX_GAIN: begin
          ctrl_q.amp_en <= pwdata[mpb_pkg::BIT_TOP];
          ctrl_q.gain   <= pwdata[6:0];
        end
        mpb_pkg::IDX_FF: begin
          ctrl_q.ff_mic  <= pwdata[mpb_pkg::FF_MIC_LSB+:2];
          ctrl_q.ff_auxiliary_input_one <= pwdata[mpb_pkg::FF_AUXILIARY_INPUT_ONE_LSB+:2];
          ctrl_q.ff_auxiliary_input_two <= pwdata[mpb_pkg::FF_AUXILIARY_INPUT_TWO_LSB+:2];
        end
        default: ctrl_q <= ctrl_q;
      endcase
    end else if (wr_en) begin
      case (idx)
        mpb_pkg::IDX_PWR: begin
          ctrl_q.pwr <= pwdata[mpb_pkg::BIT_TOP];
          ctrl_q.ss  <= pwdata[1:0];
        end
        mpb_pkg::IDX_MUTE: ctrl_q.mute   <= pwdata[mpb_pkg::BIT_TOP];
        mpb_pkg::IDX_AGC:  ctrl_q.agc_en <= pwdata[mpb_pkg::BIT_TOP];
        default:           ctrl_q        <= ctrl_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mic_bias_output_q <= 2'h0;
    end else begin
      mic_bias_output_q <= ctrl_q.bias;
    end
  end

  // ----------------------------------------------------------------
  // Soft-step tick from the internal oscillator
  // ----------------------------------------------------------------
  // The second and third stages feed the edge detector; the first may be metastable
  logic       osc_s1_q;
  logic       osc_s2_q;
  logic       osc_s3_q;
  logic [$clog2(STEP_DIV+1)-1:0] div_q;
  logic       half_q;
  logic       step_tick;
  logic       osc_edge;

  assign osc_edge = osc_s2_q & ~osc_s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_clk_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // Divider counts oscillator edges; the half rate mode skips every other tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= '0;
      half_q <= 1'b0;
    end else if (osc_edge) begin
      if (div_q == $bits(div_q)'(STEP_DIV - 1)) begin
        div_q  <= '0;
        half_q <= ~half_q;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  assign step_tick = osc_edge && (div_q == $bits(div_q)'(STEP_DIV - 1)) &&
                     ((ctrl_q.ss == mpb_pkg::SS_NORMAL) || half_q);

  // ----------------------------------------------------------------
  // Gain target and stepping
  // ----------------------------------------------------------------
  logic [6:0] src_gain;
  logic [6:0] target;
  logic       ss_on;

  assign ss_on    = (ctrl_q.ss == mpb_pkg::SS_NORMAL) || (ctrl_q.ss == mpb_pkg::SS_HALF);
  assign src_gain = ctrl_q.agc_en ? agc_gain_in : ctrl_q.gain;
  // Powering down steps to mute first so the output ramps out quietly
  assign target   = !ctrl_q.pwr                   ? mpb_pkg::GAIN_ZERO :
                    (src_gain > mpb_pkg::GAIN_MAX) ? mpb_pkg::GAIN_MAX  : src_gain;
  assign reached  = (applied_gain_q == target);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_gain_q <= mpb_pkg::GAIN_ZERO;
    end else if (!ctrl_q.amp_en) begin
      applied_gain_q <= mpb_pkg::GAIN_ZERO;
    end else if (!ss_on) begin
      applied_gain_q <= target;
    end else if (step_tick && !reached) begin
      if (applied_gain_q < target) begin
        applied_gain_q <= applied_gain_q + mpb_pkg::GAIN_STEP;
      end else begin
        applied_gain_q <= applied_gain_q - mpb_pkg::GAIN_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Feed-forward scaling
  // ----------------------------------------------------------------
  function automatic logic [8:0] scale(input logic [6:0] g, input logic [1:0] sel);
    logic [8:0] base;
    base = {2'h0, g};
    case (sel)
      mpb_pkg::FF_NOMINAL: scale = base;
      mpb_pkg::FF_PLUS:    scale = base + mpb_pkg::FF_SHIFT;
      default:             scale = base - mpb_pkg::FF_SHIFT;
    endcase
  endfunction : scale

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_gain_q <= '0;
    end else if (!ctrl_q.amp_en) begin
      eff_gain_q <= '0;
    end else begin
      eff_gain_q.mic  <= scale(applied_gain_q, ctrl_q.ff_mic);
      eff_gain_q.auxiliary_input_one <= scale(applied_gain_q, ctrl_q.ff_auxiliary_input_one);
      eff_gain_q.auxiliary_input_two <= scale(applied_gain_q, ctrl_q.ff_auxiliary_input_two);
    end
  end

  // ----------------------------------------------------------------
  // Converter power and mute
  // ----------------------------------------------------------------
  // The powered flag drops only after the gain has reached mute, so software
  // can poll it before stopping the codec clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_power_q <= 1'b0;
    end else if (ctrl_q.pwr) begin
      conv_power_q <= 1'b1;
    end else if (applied_gain_q == mpb_pkg::GAIN_ZERO) begin
      conv_power_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_data_q  <= '0;
      conv_valid_q <= 1'b0;
    end else begin
      conv_valid_q <= conv_valid_in & conv_power_q;
      if (!ctrl_q.mute && conv_valid_in && conv_power_q) begin
        conv_data_q <= conv_data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic                      reached_q;
  logic                      power_prev_q;
  logic [mpb_pkg::IRQ_W-1:0] ev;
  logic                      stat_wr;

  assign ev[mpb_pkg::IRQ_REACHED] = reached & ~reached_q;
  assign ev[mpb_pkg::IRQ_PWR]     = conv_power_q ^ power_prev_q;
  assign stat_wr = wr_en && !page1 && (idx == mpb_pkg::IDX_IRQ_STAT);

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Gain equals target out of reset, so start high to avoid a false reached edge
      reached_q    <= 1'b1;
      power_prev_q <= 1'b0;
      irq_stat_q   <= '0;
      irq_mask_q   <= '0;
      irq_q        <= 1'b0;
    end else begin
      reached_q    <= reached;
      power_prev_q <= conv_power_q;
      if (stat_wr) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[mpb_pkg::IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (wr_en && !page1 && (idx == mpb_pkg::IDX_IRQ_MASK)) begin
        irq_mask_q <= pwdata[mpb_pkg::IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_bias_wr;
    wr_en && page1 && (idx == mpb_pkg::IDX_BIAS);
  endsequence

  sequence s_amp_held;
    ctrl_q.amp_en && ss_on && $past(ctrl_q.amp_en) && $past(ss_on);
  endsequence

  // The gain register updates from the previous edge's controls, so the
  // stepping checks look one edge back before judging a change
  chk_bias_write_out: assert property (
      s_bias_wr |=> ##1 mic_bias_output_q == $past(pwdata[1:0], 2))
    else $error("bias output does not follow write");
  chk_gain_in_range: assert property (applied_gain_q <= mpb_pkg::GAIN_MAX)
    else $error("applied gain above 59.5 dB");
  chk_step_one_code: assert property (
      s_amp_held |-> (applied_gain_q == $past(applied_gain_q) ||
      applied_gain_q == $past(applied_gain_q) + mpb_pkg::GAIN_STEP ||
      applied_gain_q == $past(applied_gain_q) - mpb_pkg::GAIN_STEP))
    else $error("gain jumped by more than one step");
  chk_step_on_tick: assert property (
      s_amp_held and !$stable(applied_gain_q) |-> $past(step_tick))
    else $error("gain moved without a soft-step tick");
  chk_ss_off_jump: assert property (
      ctrl_q.amp_en && !ss_on |=> applied_gain_q == $past(target))
    else $error("disabled stepping did not apply target");
  chk_disable_zero: assert property (!ctrl_q.amp_en |=>
      applied_gain_q == mpb_pkg::GAIN_ZERO && eff_gain_q.mic == '0)
    else $error("disabled amplifier gain not 0 dB");
  chk_ff_plus_six: assert property (ctrl_q.amp_en && ctrl_q.ff_mic == mpb_pkg::FF_PLUS |=>
      eff_gain_q.mic == {2'h0, $past(applied_gain_q)} + mpb_pkg::FF_SHIFT)
    else $error("feed-forward 01 not +6 dB");
  chk_ff_minus_six: assert property (
      ctrl_q.amp_en && ctrl_q.ff_mic != mpb_pkg::FF_NOMINAL && ctrl_q.ff_mic != mpb_pkg::FF_PLUS
      |=> eff_gain_q.mic == {2'h0, $past(applied_gain_q)} - mpb_pkg::FF_SHIFT)
    else $error("feed-forward 10 or 11 not -6 dB");
  chk_agc_source: assert property (
      ctrl_q.amp_en && !ss_on && ctrl_q.pwr && ctrl_q.agc_en &&
      agc_gain_in <= mpb_pkg::GAIN_MAX |=> applied_gain_q == $past(agc_gain_in))
    else $error("AGC gain not applied");
  chk_mute_freeze: assert property (
      ctrl_q.mute && $past(ctrl_q.mute) |=> $stable(conv_data_q))
    else $error("muted output changed");
  chk_power_up: assert property (ctrl_q.pwr |=> conv_power_q)
    else $error("converter did not power up");
  chk_power_down_order: assert property ($fell(conv_power_q) |-> $past(applied_gain_q) ==
      mpb_pkg::GAIN_ZERO && !$past(ctrl_q.pwr))
    else $error("powered flag fell before mute reached");
  chk_valid_power: assert property (conv_valid_q |-> $past(conv_valid_in) && $past(conv_power_q))
    else $error("sample strobe while powered down");
  chk_irq_level: assert property (|(irq_stat_q & irq_mask_q) |=> irq_q)
    else $error("interrupt not raised");

endmodule : mpb_ctrl

/* dv/tb.sv */
// Self-checking bench for the microphone gain and bias control.
// Assumes mpb_pkg is compiled first; drives APB, oscillator and samples directly.
`timescale 1ns/100ps
module tb;
  logic                   pclk, presetn, psel, penable, pwrite;
  logic [9:0]             paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic                   pready, pslverr, err, osc, conv_valid_in, conv_valid_q;
  logic [6:0]             agc_gain_in, applied_gain_q, prev;
  logic [15:0]            conv_data_in, conv_data_q;
  logic [1:0]             mic_bias_output_q;
  mpb_pkg::mpb_eff_gain_t eff_gain_q;
  logic                   conv_power_q, irq_q, irq_a;
  int                     fail_count, compares;

  `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end

  mpb_ctrl #(.DATA_W(16), .STEP_DIV(2)) mpb_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .osc_clk_in(osc), .agc_gain_in(agc_gain_in), .conv_data_in(conv_data_in),
    .conv_valid_in(conv_valid_in), .mic_bias_output_q(mic_bias_output_q),
    .applied_gain_q(applied_gain_q), .eff_gain_q(eff_gain_q), .conv_power_q(conv_power_q),
    .conv_data_q(conv_data_q), .conv_valid_q(conv_valid_q), .irq_q(irq_q));

  // ----------------------------------------------------------------
  // Clocks, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Oscillator runs free and unrelated to pclk
  initial begin
    osc = 1'b0;
    forever #15.3 osc = ~osc;
  end
  initial begin
    #200_000;
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [9:0] adr(input logic pg, input logic [6:0] idx);
    return {pg, idx, 2'b00};
  endfunction : adr

  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask : wr

  task automatic chk_rd(input string nm, input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask : chk_rd

  // Waits for the applied gain, checking no jump above one code per cycle
  task automatic wait_gain(input logic [6:0] t);
    int n;
    n = 0;
    prev = applied_gain_q;
    while (applied_gain_q !== t && n < 2000) begin
      @(posedge pclk);
      n++;
      if (applied_gain_q !== prev)
        `CHK("gain step", 1'b1, (applied_gain_q == prev + 7'h01 || applied_gain_q == prev - 7'h01))
      prev = applied_gain_q;
    end
    `CHK("gain final", t, applied_gain_q)
  endtask : wait_gain

  task automatic pulse(input logic [15:0] d);
    @(posedge pclk);
    conv_data_in <= d; conv_valid_in <= 1'b1;
    @(posedge pclk);
    conv_valid_in <= 1'b0; conv_data_in <= ~d;
    @(posedge pclk);
    `CHK("conv valid", 1'b1, conv_valid_q)
    repeat (2) @(posedge pclk);
  endtask : pulse

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; agc_gain_in = 7'h10; conv_data_in = 16'h0000; conv_valid_in = 1'b0;
    fail_count = 0; compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("gain rst", 7'h00, applied_gain_q)
    `CHK("irq rst", 1'b0, irq_q)
    chk_rd("gain reg rst", adr(1, mpb_pkg::IDX_GAIN), 32'h0000_0000);
    chk_rd("pwr reg rst", adr(0, mpb_pkg::IDX_PWR), 32'h0000_0000);
    chk_rd("ff rst", adr(1, mpb_pkg::IDX_FF), 32'h0000_0000);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(adr(1, mpb_pkg::IDX_BIAS), 8'(i));
      repeat (2) @(posedge pclk);
      `CHK("bias out", 2'(i), mic_bias_output_q)
      chk_rd("bias rd", adr(1, mpb_pkg::IDX_BIAS), 32'(i));
    end
    wr(adr(0, 7'h10), 8'hff);
    `CHK("unmapped err", 1'b1, err)
    chk_rd("unmapped rd", adr(0, 7'h10), 32'h0000_0000);
    $display("bias and map test done");
    wr(adr(0, mpb_pkg::IDX_PWR), 8'h80);
    repeat (4) @(posedge pclk);
    `CHK("conv power", 1'b1, conv_power_q)
    chk_rd("status up", adr(0, mpb_pkg::IDX_STATUS), 32'h0000_00c0);
    wr(adr(1, mpb_pkg::IDX_GAIN), 8'h84);
    wait_gain(7'h04);
    repeat (2) @(posedge pclk);
    `CHK("eff mic", 9'h004, eff_gain_q.mic)
    chk_rd("reached", adr(0, mpb_pkg::IDX_STATUS), 32'h0000_00c0);
    wr(adr(1, mpb_pkg::IDX_FF), 8'h64);
    repeat (3) @(posedge pclk);
    `CHK("ff mic 01", 9'h010, eff_gain_q.mic)
    `CHK("ff auxiliary_input_one 10", 9'h1f8, eff_gain_q.auxiliary_input_one)
    `CHK("ff auxiliary_input_two 01", 9'h010, eff_gain_q.auxiliary_input_two)
    wr(adr(1, mpb_pkg::IDX_FF), 8'hd8);
    repeat (3) @(posedge pclk);
    `CHK("ff mic 11", 9'h1f8, eff_gain_q.mic)
    `CHK("ff auxiliary_input_one 01", 9'h010, eff_gain_q.auxiliary_input_one)
    `CHK("ff auxiliary_input_two 10", 9'h1f8, eff_gain_q.auxiliary_input_two)
    wr(adr(1, mpb_pkg::IDX_FF), 8'h00);
    $display("gain and feed-forward test done");
    chk_rd("irq stat", adr(0, mpb_pkg::IDX_IRQ_STAT), 32'h0000_0003);
    wr(adr(0, mpb_pkg::IDX_IRQ_MASK), 8'h00);
    repeat (2) @(posedge pclk);
    irq_a = irq_q;
    wr(adr(0, mpb_pkg::IDX_IRQ_MASK), 8'h03);
    repeat (2) @(posedge pclk);
    `CHK("irq masking", 1'b0, irq_a)
    `CHK("irq unmasked", 1'b1, irq_q)
    wr(adr(0, mpb_pkg::IDX_IRQ_STAT), 8'h03);
    repeat (2) @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq_q)
    chk_rd("irq stat clr", adr(0, mpb_pkg::IDX_IRQ_STAT), 32'h0000_0000);
    $display("irq test done");
    wr(adr(0, mpb_pkg::IDX_PWR), 8'h81);
    wr(adr(1, mpb_pkg::IDX_GAIN), 8'h88);
    wait_gain(7'h08);
    wr(adr(0, mpb_pkg::IDX_PWR), 8'h82);
    wr(adr(1, mpb_pkg::IDX_GAIN), 8'hff);
    repeat (2) @(posedge pclk);
    `CHK("clamp jump", mpb_pkg::GAIN_MAX, applied_gain_q)
    wr(adr(0, mpb_pkg::IDX_AGC), 8'h80);
    repeat (2) @(posedge pclk);
    `CHK("agc gain", 7'h10, applied_gain_q)
    wr(adr(0, mpb_pkg::IDX_AGC), 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("fixed gain", mpb_pkg::GAIN_MAX, applied_gain_q)
    wr(adr(1, mpb_pkg::IDX_GAIN), 8'h05);
    repeat (3) @(posedge pclk);
    `CHK("amp off", 7'h00, applied_gain_q)
    `CHK("amp off eff", 9'h000, eff_gain_q.mic)
    wr(adr(0, mpb_pkg::IDX_PWR), 8'h83);
    wr(adr(1, mpb_pkg::IDX_GAIN), 8'h84);
    repeat (2) @(posedge pclk);
    `CHK("ss 11 jump", 7'h04, applied_gain_q)
    wr(adr(0, mpb_pkg::IDX_PWR), 8'h80);
    $display("soft-step mode test done");
    pulse(16'h1234);
    `CHK("conv data", 16'h1234, conv_data_q)
    wr(adr(0, mpb_pkg::IDX_MUTE), 8'h80);
    pulse(16'habcd);
    `CHK("muted hold", 16'h1234, conv_data_q)
    wr(adr(0, mpb_pkg::IDX_MUTE), 8'h00);
    pulse(16'habcd);
    `CHK("unmuted", 16'habcd, conv_data_q)
    $display("mute test done");
    wr(adr(0, mpb_pkg::IDX_PWR), 8'h00);
    wait_gain(7'h00);
    `CHK("power held", 1'b1, conv_power_q)
    repeat (2) @(posedge pclk);
    `CHK("power down", 1'b0, conv_power_q)
    chk_rd("status down", adr(0, mpb_pkg::IDX_STATUS), 32'h0000_0080);
    chk_rd("irq pwr", adr(0, mpb_pkg::IDX_IRQ_STAT), 32'h0000_0003);
    $display("power-down test done");
    give_verdict();
  end
endmodule : tb
